// file: core/uart_line_status.sv
// line status register, transmit status and axi4-lite slave
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module uart_line_status
  import line_status_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  input  wire logic       rxd_pin,
  input  wire logic       bit_tick,
  input  wire logic       rx_char_valid,
  input  wire logic [7:0] rx_char_data,
  input  wire logic       rx_char_parity,
  input  wire logic       rx_char_stop_ok,
  input  wire logic       rx_pop,
  input  wire logic       thr_write,
  input  wire logic       thr_to_shift,
  input  wire logic       tx_fifo_empty,
  input  wire logic       tx_shift_empty,
  output logic [7:0]      rx_data_ff,
  output logic [7:0]      line_status_ff,
  output logic            thr_irq_ff,
  output logic            irq_ff
);
  logic               rxd_meta_ff;
  logic               rxd_sync_ff;
  logic [7:0]         control_ff;
  logic [EV_W-1:0]    int_status_ff;
  logic [EV_W-1:0]    int_enable_ff;
  logic               thr_empty_ff;
  logic               overrun_ff;
  logic               aw_got_ff;
  logic               w_got_ff;
  logic [7:0]         waddr_ff;
  logic [31:0]        wdata_ff;
  logic [3:0]         wstrb_ff;
  logic [ENTRY_W-1:0] head;
  logic               rx_empty;
  logic               rx_full;
  logic               err_any;
  logic               brk_push;
  logic               push;
  logic [ENTRY_W-1:0] push_data;
  logic               fifo_mode;
  logic               pe_now;
  logic               temt;
  logic               aw_hs;
  logic               w_hs;
  logic               b_hs;
  logic               ar_hs;
  logic               r_hs;
  logic               do_write;
  logic               ls_read;
  logic [EV_W-1:0]    events;
  logic [EV_W-1:0]    wr_clear;
  logic [7:0]         rd_val;
  logic               rd_ok;

  function automatic logic [7:0] len_mask(input logic [1:0] code);
    len_mask = 8'hff >> (2'h3 - code);
  endfunction

  assign fifo_mode = control_ff[CT_FIFO];
  assign aw_hs     = s_axi_awvalid && s_axi_awready;
  assign w_hs      = s_axi_wvalid && s_axi_wready;
  assign b_hs      = s_axi_bvalid && s_axi_bready;
  assign ar_hs     = s_axi_arvalid && s_axi_arready;
  assign r_hs      = s_axi_rvalid && s_axi_rready;
  assign do_write  = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign ls_read   = ar_hs && (s_axi_araddr == OFS_LINE_STATUS);

  // rx pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_meta_ff <= 1'b1;
      rxd_sync_ff <= 1'b1;
    end else if (ce) begin
      rxd_meta_ff <= rxd_pin;
      rxd_sync_ff <= rxd_meta_ff;
    end
  end

  break_detect u_break (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .rxd        (rxd_sync_ff),
    .bit_tick   (bit_tick),
    .frame_bits (frame_len(control_ff)),
    .brk_push   (brk_push)
  );

  // received character check and fifo entry
  assign pe_now = control_ff[CT_PEN] && (rx_char_parity !=
    (control_ff[CT_EVEN] ? ^(rx_char_data & len_mask(control_ff[5:4]))
                         : ~^(rx_char_data & len_mask(control_ff[5:4]))));
  assign push      = rx_char_valid || brk_push;
  assign push_data = brk_push ? {1'b1, 2'b00, 8'h00} // see RULE_09
                   : {1'b0, !rx_char_stop_ok, pe_now, rx_char_data}; // see RULE_10 RULE_11

  rx_error_fifo u_fifo (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ce          (ce),
    .single_mode (!fifo_mode),
    .push        (push),
    .push_data   (push_data),
    .pop         (rx_pop),
    .head        (head),
    .empty       (rx_empty),
    .full        (rx_full),
    .err_any     (err_any)
  );

  // overrun, cleared by reading line status, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_ff <= 1'b0;
    end else if (ce) begin
      if (push && rx_full) begin
        overrun_ff <= 1'b1; // see RULE_14
      end else if (ls_read) begin
        overrun_ff <= 1'b0;
      end
    end
  end

  // holding register empty
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_empty_ff <= 1'b1;
    end else if (ce) begin
      if (fifo_mode) begin
        thr_empty_ff <= tx_fifo_empty && !thr_write; // see RULE_06
      end else if (thr_to_shift) begin
        thr_empty_ff <= 1'b1; // see RULE_05
      end else if (thr_write) begin
        thr_empty_ff <= 1'b0; // see RULE_05
      end
    end
  end

  assign temt = tx_shift_empty
              && (fifo_mode ? tx_fifo_empty // see RULE_04
                            : thr_empty_ff); // see RULE_03

  // line status image
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_status_ff <= LINE_STATUS_RST; // see RULE_13
      rx_data_ff     <= 8'h00;
    end else if (ce) begin
      line_status_ff[LS_ERR] <= err_any; // see RULE_01 RULE_02
      line_status_ff[LS_TE]  <= temt;
      line_status_ff[LS_THE] <= thr_empty_ff;
      line_status_ff[LS_BI]  <= !rx_empty && head[ENT_BI]; // see RULE_12
      line_status_ff[LS_FE]  <= !rx_empty && head[ENT_FE]; // see RULE_12
      line_status_ff[LS_PE]  <= !rx_empty && head[ENT_PE]; // see RULE_12
      line_status_ff[LS_OE]  <= overrun_ff;
      line_status_ff[LS_RDY] <= !rx_empty; // see RULE_15
      rx_data_ff             <= rx_empty ? 8'h00 : head[7:0];
    end
  end

  // interrupts
  assign events[EV_RDY]  = push && !rx_full;
  assign events[EV_OE]   = push && rx_full;
  assign events[EV_LINE] = push && (push_data[ENT_PE] || push_data[ENT_FE]
                                    || push_data[ENT_BI]);
  assign events[EV_THE]  = thr_empty_ff && !line_status_ff[LS_THE];
  assign wr_clear = (do_write && waddr_ff == OFS_INT_CLEAR && wstrb_ff[0])
                  ? wdata_ff[EV_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status_ff <= '0;
      irq_ff        <= 1'b0;
      thr_irq_ff    <= 1'b0;
    end else if (ce) begin
      int_status_ff <= (int_status_ff & ~wr_clear) | events;
      irq_ff        <= |(int_status_ff & int_enable_ff);
      thr_irq_ff    <= thr_empty_ff && control_ff[CT_THRIE]; // see RULE_07
    end
  end

  // axi write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      waddr_ff      <= 8'h00;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
    end else if (ce) begin
      if (aw_hs) begin
        aw_got_ff     <= 1'b1;
        s_axi_awready <= 1'b0;
        waddr_ff      <= s_axi_awaddr;
      end else if (b_hs) begin
        aw_got_ff     <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      if (w_hs) begin
        w_got_ff     <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
      end else if (b_hs) begin
        w_got_ff     <= 1'b0;
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (waddr_ff == OFS_CONTROL || waddr_ff == OFS_INT_CLEAR
                         || waddr_ff == OFS_INT_ENABLE) ? RESP_OKAY
                                                        : RESP_SLVERR;
      end else if (b_hs) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // writable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_ff    <= CONTROL_RST;
      int_enable_ff <= '0;
    end else if (ce && do_write && wstrb_ff[0]) begin
      if (waddr_ff == OFS_CONTROL) begin
        control_ff <= wdata_ff[7:0];
      end
      if (waddr_ff == OFS_INT_ENABLE) begin
        int_enable_ff <= wdata_ff[EV_W-1:0];
      end
    end
  end

  // axi read channel
  always_comb begin
    rd_val = 8'h00;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      OFS_LINE_STATUS: rd_val = line_status_ff;
      OFS_CONTROL:     rd_val = control_ff;
      OFS_INT_STATUS:  rd_val = {4'h0, int_status_ff};
      OFS_INT_CLEAR:   rd_val = 8'h00;
      OFS_INT_ENABLE:  rd_val = {4'h0, int_enable_ff};
      default:         rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_val};
        s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (r_hs) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
      end
    end
  end

  sequence push_full_s;
    ce && push && rx_full;
  endsequence
  sequence oe_shown_s;
    ##2 line_status_ff[LS_OE];
  endsequence

  data_err_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_01
    ce && err_any |=> line_status_ff[LS_ERR])
    else $error("data error bit missing");
  data_clr_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_02
    ce && !err_any |=> !line_status_ff[LS_ERR])
    else $error("data error bit stuck");
  temt_plain_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_03
    ce && !fifo_mode |=> line_status_ff[LS_TE]
      == $past(thr_empty_ff && tx_shift_empty))
    else $error("transmit empty wrong in plain mode");
  temt_fifo_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_04
    ce && fifo_mode && tx_fifo_empty && tx_shift_empty
      |=> line_status_ff[LS_TE])
    else $error("transmit empty missing in fifo mode");
  thr_move_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_05
    ce && !fifo_mode && thr_to_shift |=> thr_empty_ff ##1 line_status_ff[LS_THE])
    else $error("holding empty not set on move");
  thr_load_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_05
    ce && !fifo_mode && thr_write && !thr_to_shift |=> !thr_empty_ff)
    else $error("holding empty not cleared on load");
  thr_fifo_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_06
    ce && fifo_mode |=> thr_empty_ff == $past(tx_fifo_empty && !thr_write))
    else $error("holding empty not tracking fifo");
  thr_irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_07
    ce && thr_empty_ff && control_ff[CT_THRIE] |=> thr_irq_ff)
    else $error("transmit request missing");
  reset_clear_a: assert property (@(posedge aclk) // see RULE_13
    !aresetn |=> line_status_ff[LS_ERR] == 1'b0 && line_status_ff[LS_BI] == 1'b0
      && line_status_ff[LS_FE] == 1'b0 && line_status_ff[LS_PE] == 1'b0)
    else $error("error bits set after reset");
  overrun_a: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // see RULE_14
    push_full_s |-> oe_shown_s)
    else $error("overrun not reported");
  data_ready_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_15
    ce |=> line_status_ff[LS_RDY] == $past(!rx_empty))
    else $error("data ready wrong");
  head_err_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_12
    ce && rx_empty |=> !line_status_ff[LS_PE] && !line_status_ff[LS_FE])
    else $error("error shown for empty fifo");
endmodule // uart_line_status
`default_nettype wire

// file: include/line_status_pkg.sv
// constants, offsets and field layout of the line status block
// Functional notes
// RULE_01: data error set when any queued char errs
// RULE_02: data error clears once no queued char errs
// RULE_03: non-fifo: tx empty when holding and shift empty
// RULE_04: fifo mode: tx empty when fifo and shift empty
// RULE_05: non-fifo: holding empty on move, clears on load
// RULE_06: fifo mode: holding empty tracks fifo empty, write clears
// RULE_07: holding empty plus enable raises transmit request
// RULE_08: break when line low one whole frame
// RULE_09: one break character per break condition
// RULE_10: framing error when stop bit missing
// RULE_11: parity error when parity mismatches setting
// RULE_12: fifo mode: errors belong to head character
// RULE_13: error and break bits zero after reset
// RULE_14: overrun when char completes with fifo full
// RULE_15: data ready while any character is held
// RULE_16: each fifo entry stores parity, framing, break
package line_status_pkg;
  localparam int         RX_DEPTH      = 32;
  localparam int         RX_PTR_W      = 5;
  localparam int         RX_CNT_W      = 6;
  localparam int         ENTRY_W       = 11;
  localparam int         ENT_PE        = 8;
  localparam int         ENT_FE        = 9;
  localparam int         ENT_BI        = 10;
  // register byte offsets
  localparam logic [7:0] OFS_LINE_STATUS = 8'h00;
  localparam logic [7:0] OFS_CONTROL     = 8'h04;
  localparam logic [7:0] OFS_INT_STATUS  = 8'h08;
  localparam logic [7:0] OFS_INT_CLEAR   = 8'h0c;
  localparam logic [7:0] OFS_INT_ENABLE  = 8'h10;
  // line status bit positions
  localparam int         LS_RDY = 0;
  localparam int         LS_OE  = 1;
  localparam int         LS_PE  = 2;
  localparam int         LS_FE  = 3;
  localparam int         LS_BI  = 4;
  localparam int         LS_THE = 5;
  localparam int         LS_TE  = 6;
  localparam int         LS_ERR = 7;
  // control bit positions
  localparam int         CT_FIFO  = 0;
  localparam int         CT_THRIE = 1;
  localparam int         CT_PEN   = 2;
  localparam int         CT_EVEN  = 3;
  localparam int         CT_LEN   = 4;
  localparam int         CT_STOP2 = 6;
  // interrupt event bit positions
  localparam int         EV_RDY = 0;
  localparam int         EV_OE  = 1;
  localparam int         EV_LINE = 2;
  localparam int         EV_THE = 3;
  localparam int         EV_W   = 4;
  // reset values and axi response codes
  localparam logic [7:0] CONTROL_RST     = 8'h30;
  localparam logic [7:0] LINE_STATUS_RST = 8'h60;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  // frame length in bit times
  function automatic logic [3:0] frame_len(input logic [7:0] ctl);
    frame_len = 4'h7 + {2'h0, ctl[CT_LEN+1:CT_LEN]} + {3'h0, ctl[CT_PEN]}
              + {3'h0, ctl[CT_STOP2]};
  endfunction
endpackage

// file: core/rx_error_fifo.sv
// receive fifo with per-entry error flags
`timescale 1ns/1ns
`default_nettype none
module rx_error_fifo
  import line_status_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic               single_mode,
  input  wire logic               push,
  input  wire logic [ENTRY_W-1:0] push_data,
  input  wire logic               pop,
  output logic      [ENTRY_W-1:0] head,
  output logic                    empty,
  output logic                    full,
  output logic                    err_any
);
  logic [ENTRY_W-1:0]  mem [RX_DEPTH];
  logic [RX_PTR_W-1:0] wr_ff;
  logic [RX_PTR_W-1:0] rd_ff;
  logic [RX_CNT_W-1:0] cnt_ff;
  logic [RX_CNT_W-1:0] err_cnt_ff;
  logic                do_push;
  logic                do_pop;

  function automatic logic has_err(input logic [ENTRY_W-1:0] e);
    has_err = e[ENT_PE] | e[ENT_FE] | e[ENT_BI];
  endfunction

  assign empty   = (cnt_ff == '0);
  assign full    = single_mode ? !empty : (cnt_ff == RX_CNT_W'(RX_DEPTH));
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign head    = mem[rd_ff];
  assign err_any = (err_cnt_ff != '0);

  always_ff @(posedge aclk) begin
    if (ce && do_push) begin
      mem[wr_ff] <= push_data; // see RULE_16
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else if (ce) begin
      if (do_push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + RX_CNT_W'(do_push) - RX_CNT_W'(do_pop);
    end
  end

  // count of queued entries that carry an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_cnt_ff <= '0;
    end else if (ce) begin
      err_cnt_ff <= err_cnt_ff
                  + RX_CNT_W'(do_push && has_err(push_data))  // see RULE_01
                  - RX_CNT_W'(do_pop && has_err(head));       // see RULE_02
    end
  end

  err_count_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_02
    err_cnt_ff <= cnt_ff)
    else $error("error count exceeds fill level");
endmodule // rx_error_fifo
`default_nettype wire

// file: core/break_detect.sv
// detects a whole frame of low line, one pulse per break
`timescale 1ns/1ns
`default_nettype none
module break_detect (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       rxd,
  input  wire logic       bit_tick,
  input  wire logic [3:0] frame_bits,
  output logic            brk_push
);
  logic [3:0] cnt_ff;
  logic       armed_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff   <= 4'h0;
      armed_ff <= 1'b1;
      brk_push <= 1'b0;
    end else if (ce) begin
      brk_push <= 1'b0;
      if (rxd) begin
        cnt_ff   <= 4'h0;
        armed_ff <= 1'b1; // see RULE_09
      end else if (bit_tick && armed_ff) begin
        if (cnt_ff + 4'h1 >= frame_bits) begin
          brk_push <= 1'b1; // see RULE_08
          armed_ff <= 1'b0; // see RULE_09
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
    end
  end

  sequence brk_seen_s;
    brk_push;
  endsequence
  sequence no_rearm_s;
    rxd == 1'b0;
  endsequence

  break_once_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_09
    brk_seen_s ##1 no_rearm_s |-> !brk_push)
    else $error("second break pulse without line release");

  break_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_08
    brk_push |-> $past(rxd == 1'b0 && bit_tick))
    else $error("break pulse without low line tick");
endmodule // break_detect
`default_nettype wire

// file: tb/axi_host_model.sv
// axi4-lite host model issuing one read or write at a time
`timescale 1ns/1ns
`default_nettype none
module axi_host_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        wr_req,
  input  wire logic        rd_req,
  input  wire logic [7:0]  req_addr,
  input  wire logic [31:0] req_wdata,
  output logic             req_done,
  output logic [31:0]      got_data,
  output logic [1:0]       got_resp,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  logic busy_ff;
  initial begin
    {req_done, awvalid, wvalid, bready, arvalid, rready, busy_ff} = '0;
    {got_data, got_resp, awaddr, wdata, araddr} = '0;
  end
  assign wstrb = 4'hf;
  // released payload toggles so stale values never look valid
  always @(posedge aclk) begin
    req_done <= 1'b0;
    if (!aresetn) begin
      {awvalid, wvalid, bready, arvalid, rready, busy_ff} <= '0;
    end else if (!busy_ff && !req_done && (wr_req || rd_req)) begin
      {awvalid, wvalid, bready} <= {3{wr_req}};
      {arvalid, rready} <= {2{!wr_req}};
      {awaddr, araddr, wdata} <= {req_addr, req_addr, req_wdata};
      busy_ff <= 1'b1;
    end else begin
      if (awready) {awvalid, awaddr} <= {1'b0, ~awaddr};
      if (wready) {wvalid, wdata} <= {1'b0, ~wdata};
      if (arready) {arvalid, araddr} <= {1'b0, ~araddr};
      if ((bvalid && bready) || (rvalid && rready)) begin
        {bready, rready, busy_ff, req_done} <= 4'h1;
        got_resp <= bvalid ? bresp : rresp;
        got_data <= rdata;
      end
    end
  end
endmodule // axi_host_model
`default_nettype wire

// file: tb/uart_line_status_tb_top.sv
// self-checking bench for the line status block
`timescale 1ns/1ns
`default_nettype none
module uart_line_status_tb_top
  import line_status_pkg::*;
;
  logic        aclk, aresetn, rxd, tick, cv, par, stop_ok, pop, thw, ths;
  logic        tfe, tse, wr_req, rd_req, req_done, awvalid, awready, wvalid;
  logic        wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        thr_irq, irq, ce;
  logic [1:0]  bresp, rresp, got_resp;
  logic [3:0]  wstrb;
  logic [7:0]  awaddr, araddr, addr, cdata, rx_data, ls, mode;
  logic [31:0] wdata, rdata, wd, got_data;
  logic [10:0] q[$];
  int          bad_count = 0;
  int          total_checks = 0;

  axi_host_model host (.aclk(aclk), .aresetn(aresetn), .wr_req(wr_req),
    .rd_req(rd_req), .req_addr(addr), .req_wdata(wd), .req_done(req_done),
    .got_data(got_data), .got_resp(got_resp), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  uart_line_status DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd_pin(rxd),
    .bit_tick(tick), .rx_char_valid(cv), .rx_char_data(cdata),
    .rx_char_parity(par), .rx_char_stop_ok(stop_ok), .rx_pop(pop),
    .thr_write(thw), .thr_to_shift(ths), .tx_fifo_empty(tfe),
    .tx_shift_empty(tse), .rx_data_ff(rx_data), .line_status_ff(ls),
    .thr_irq_ff(thr_irq), .irq_ff(irq));

  always #10 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    wr_req <= w;
    rd_req <= !w;
    addr <= a;
    wd <= d;
    do begin
      @(posedge aclk);
      n++;
    end while (req_done !== 1'b1 && n < 200);
    if (req_done !== 1'b1) bad_count++;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic settle;
    repeat (4) @(posedge aclk);
  endtask

  // expected fifo entry: parity over the configured data bits only
  function automatic logic [10:0] exp_entry(input logic [7:0] c, d,
                                            input logic p, s);
    logic [7:0] m;
    m = d & (8'hff >> (3 - c[5:4]));
    return {1'b0, !s, c[CT_PEN] && (p != (^m ^ !c[CT_EVEN])), d};
  endfunction

  task automatic push(input logic [7:0] d, input logic p, s);
    @(posedge aclk);
    {cv, cdata, par, stop_ok} <= {1'b1, d, p, s};
    @(posedge aclk);
    cv <= 1'b0;
    q.push_back(exp_entry(mode, d, p, s));
  endtask

  task automatic pulse(input int k);
    @(posedge aclk);
    {pop, thw, ths} <= {k == 0, k == 1, k == 2};
    @(posedge aclk);
    {pop, thw, ths} <= 3'h0;
  endtask

  task automatic tick_n(input int n);
    repeat (n) begin
      @(posedge aclk);
      tick <= 1'b1;
      @(posedge aclk);
      tick <= 1'b0;
    end
  endtask

  task automatic chk_head;
    logic err = 1'b0;
    foreach (q[i]) err = err | (|q[i][10:8]);
    settle();
    chk("ready", ls[LS_RDY], q.size() > 0);
    chk("data_err", ls[LS_ERR], err);
    if (q.size() > 0) begin
      chk("parity", ls[LS_PE], q[0][ENT_PE]);
      chk("framing", ls[LS_FE], q[0][ENT_FE]);
      chk("break", ls[LS_BI], q[0][ENT_BI]);
      chk("head", rx_data, q[0][7:0]);
    end
  endtask

  initial begin
    {aclk, aresetn, tick, cv, par, pop, thw, ths, wr_req, rd_req} = '0;
    {rxd, stop_ok, tfe, tse, ce} = 5'h1f;
    {cdata, addr, wd} = '0;
    void'($urandom(32'hbf0d));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("ls_reset", ls, LINE_STATUS_RST);
    bus(1'b0, OFS_LINE_STATUS, 32'h0);
    chk("ls_read", got_data, 32'h60);
    bus(1'b0, OFS_CONTROL, 32'h0);
    chk("ctl_reset", got_data, {24'h0, CONTROL_RST});
    bus(1'b0, 8'h14, 32'h0);
    chk("unmapped", got_resp, RESP_SLVERR);
    bus(1'b1, OFS_LINE_STATUS, 32'hff);
    chk("ro_resp", got_resp, RESP_SLVERR);
    chk("ro_keep", ls, 8'h60);
    // transmit side, single holding register
    bus(1'b1, OFS_CONTROL, 32'h32);
    settle();
    chk("thr_irq_on", thr_irq, 1'b1);
    pulse(1);
    settle();
    chk("hold_load", ls[6:5], 2'b00);
    chk("thr_irq_off", thr_irq, 1'b0);
    tse <= 1'b0;
    pulse(2);
    settle();
    chk("hold_move", ls[6:5], 2'b01);
    tse <= 1'b1;
    settle();
    chk("tx_empty", ls[6:5], 2'b11);
    // a load while frozen must leave the holding state alone
    ce <= 1'b0;
    pulse(1);
    ce <= 1'b1;
    settle();
    chk("ce_freeze", ls[6:5], 2'b11);
    // transmit side, fifo mode, all empty combinations
    mode = 8'h3f;
    bus(1'b1, OFS_CONTROL, {24'h0, mode});
    for (int i = 0; i < 4; i++) begin
      {tfe, tse} <= i[1:0];
      settle();
      chk("fifo_tx", ls[6:5], {i[1] & i[0], i[1]});
    end
    // interrupt raise, clear, mask
    bus(1'b1, OFS_INT_ENABLE, 32'h1);
    push(8'h55, 1'b1, 1'b1);
    settle();
    chk("irq_set", irq, 1'b1);
    bus(1'b1, OFS_INT_CLEAR, 32'h1);
    settle();
    chk("irq_clr", irq, 1'b0);
    bus(1'b1, OFS_INT_ENABLE, 32'h0);
    for (int i = 0; i < 12; i++) push(8'($urandom), 1'($urandom), 1'($urandom));
    push(8'h03, 1'b0, 1'b1);
    bus(1'b0, OFS_INT_STATUS, 32'h0);
    chk("int_pend", got_data[EV_RDY], 1'b1);
    chk("irq_mask", irq, 1'b0);
    while (q.size() > 0) begin
      chk_head();
      pulse(0);
      void'(q.pop_front());
    end
    chk_head();
    // overrun with full fifo
    for (int i = 0; i < 33; i++) push(8'(i), ^8'(i), 1'b1);
    settle();
    chk("overrun", ls[LS_OE], 1'b1);
    bus(1'b0, OFS_LINE_STATUS, 32'h0);
    chk("oe_read", got_data[LS_OE], 1'b1);
    settle();
    chk("oe_clear", ls[LS_OE], 1'b0);
    for (int i = 0; i < 32; i++) begin
      chk("kept", rx_data, 8'(i));
      pulse(0);
      settle();
    end
    q.delete();
    chk_head();
    // long break on the line
    rxd <= 1'b0;
    tick_n(1 + 8 + 1 + 1); // one frame, first tick lost in the pin sync
    settle();
    chk("no_break_yet", ls[LS_RDY], 1'b0);
    tick_n(1);
    settle();
    chk("break_at_frame", ls[LS_RDY], 1'b1);
    tick_n(30);
    rxd <= 1'b1;
    tick_n(4);
    q.push_back(11'h400);
    chk_head();
    pulse(0);
    void'(q.pop_front());
    chk_head();
    chk("one_break", ls[LS_RDY], 1'b0);
    // odd parity, seven data bits, single holding register
    mode = 8'h26;
    bus(1'b1, OFS_CONTROL, {24'h0, mode});
    push(8'h31, 1'b0, 1'b0);
    chk_head();
    pulse(0);
    void'(q.pop_front());
    chk_head();
    end_sim();
  end

  initial begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    end_sim();
  end
endmodule // uart_line_status_tb_top
`default_nettype wire
